// ===== hw/qmf_device.sv
// Device end: queue manager with transmit and receive packet memories.
//
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "qmf_params.svh"
// Functional notes
// - Two separate 4KB packet memories, TX and RX
// - TX frame: control, byte count, then data
// - Frame data area at most 1916 bytes
// - Host omits checksum when hardware generates it
// - Many frames may queue while memory remains
// - TX status follows frame now being sent
// - Host gives one aligned control word per frame
// - Control bit 15 raises interrupt on completion
// - Control bits 9-8 force destination ports
// - Zero port bits mean normal table lookup
// - Control bits 5-0 tag reported in status
// - Count bits 10-0 size frame storage compactly
// - Host writes correct nonzero byte count
// - Host supplies all bytes, addresses included
// - Length/type field passes through untouched
// - RX frame: status, byte count, then data
// - Checksum stripped from RX when enabled
// - Transmit and receive events raise flags
// - Valid bit only on a complete frame
// - Status bits 9-8 give source port
module qmf_device #(
    parameter int AW = `QMF_ADDR_W
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    qmf_if.dev               q,
    output logic             mac_tx_valid,  // Transmit byte offered
    input  wire logic        mac_tx_ready,  // MAC takes it
    output logic [7:0]       mac_tx_data,   // Transmit byte
    output logic             mac_tx_last,   // Last byte of frame
    output logic [1:0]       mac_tx_ports,  // Forced egress ports
    output logic             mac_tx_lookup, // Forward by address table
    output logic             mac_tx_add_fcs,// MAC appends checksum
    input  wire logic        mac_rx_valid,  // Received byte offered
    output logic             mac_rx_ready,  // Room for it
    input  wire logic [7:0]  mac_rx_data,   // Received byte
    input  wire logic        mac_rx_last,   // Last byte, checksum included
    input  wire logic [1:0]  mac_rx_port    // Source port code, held over frame
);
    ////////////////////////////////////////////////////////////////////////
    // Parameter check and memories
    if (AW != `QMF_ADDR_W) begin : g_bad_aw
        $error("qmf_device: only 2048-word memories are supported");
    end

    logic [15:0] tx_mem [0:(1<<AW)-1]; // Transmit packet memory
    logic [15:0] rx_mem [0:(1<<AW)-1]; // Receive packet memory

    ////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic [11:0]      tx_wp;     // Host write pointer
        logic [11:0]      tx_rp;     // MAC-side read pointer
        logic [10:0]      tx_frames; // Complete frames waiting
        qmf_pkg::qmf_tx_e tx_st;     // Drain state
        logic [15:0]      tx_ctrl;   // Control word of frame in flight
        logic [10:0]      tx_left;   // Bytes still to send
        logic             tx_hi;     // Next byte is the upper one
        logic [15:0]      tx_stat;   // Status of frame in flight
        logic [1:0]       irq;       // Sticky events
        logic [11:0]      rx_base;   // Header slot of frame being stored
        logic [11:0]      rx_wp;     // Next data word slot
        logic [11:0]      rx_rp;     // Host read pointer
        logic [10:0]      rx_frames; // Committed frames waiting
        logic [10:0]      rx_len;    // Bytes received so far
        logic [7:0]       rx_lo;     // Earlier byte awaiting its partner
        qmf_pkg::qmf_rd_e rd_st;     // Read-out state
        logic [10:0]      rd_left;   // Data words still to read
    } qmf_dev_s;

    qmf_dev_s st_r;
    qmf_dev_s st_nxt;

    // Words needed for a byte count
    function automatic logic [11:0] qmf_words(input logic [10:0] n);
        logic [11:0] s;
        s = {1'b0, n} + 12'h001;
        return {1'b0, s[11:1]};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Combinational view of the handshakes
    logic        tx_take;   // Host word accepted
    logic        tx_out;    // MAC byte accepted
    logic        rx_take;   // Received byte accepted
    logic        rd_take;   // Host took a receive word
    logic [10:0] rx_len_n;  // Count including the new byte
    logic [10:0] rx_eff;    // Count after optional stripping
    logic        rx_drop;   // Frame cannot be kept
    logic        rx_commit; // Frame header written this cycle
    logic [15:0] rx_status; // Status word to store

    always_comb begin
        tx_take   = q.tx_wvalid && q.tx_wready;
        tx_out    = mac_tx_valid && mac_tx_ready;
        rx_take   = mac_rx_valid && mac_rx_ready;
        rd_take   = q.rx_rvalid && q.rx_rready;
        // Saturate so an oversize frame cannot wrap into a short one
        rx_len_n  = (st_r.rx_len == 11'h7FF) ? st_r.rx_len : st_r.rx_len + 11'h001;
        // Strip by shortening the count; the checksum bytes still land in data slots that the next frame reuses
        rx_eff    = q.crc_strip_en ? rx_len_n - `QMF_FCS_BYTES : rx_len_n;
        rx_drop   = (q.crc_strip_en && rx_len_n <= `QMF_FCS_BYTES) || (rx_eff > `QMF_MAX_DATA);
        rx_commit = rx_take && mac_rx_last && !rx_drop;
        rx_status = 16'h0000;
        rx_status[`QMF_ARRIVED_VALID] = 1'b1;
        rx_status[`QMF_PORT_HI:`QMF_PORT_LO] = mac_rx_port;
    end

    // Room checks: receive keeps one slot spare for a trailing odd byte; transmit keeps none
    assign q.tx_wready   = (st_r.tx_wp - st_r.tx_rp) < `QMF_DEPTH;
    assign mac_rx_ready  = (st_r.rx_wp - st_r.rx_rp) < (`QMF_DEPTH - 12'h001);

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        st_nxt = st_r;
        // Host words land in sequence, so frames pack back to back
        if (tx_take) begin
            st_nxt.tx_wp = st_r.tx_wp + 12'h001;
        end
        // Transmit drain toward the MAC
        case (st_r.tx_st)
            qmf_pkg::QMF_TX_IDLE: begin
                if (st_r.tx_frames != 11'h000) begin
                    // First word of every frame is its control word
                    st_nxt.tx_ctrl = tx_mem[st_r.tx_rp[AW-1:0]];
                    st_nxt.tx_rp   = st_r.tx_rp + 12'h001;
                    st_nxt.tx_st   = qmf_pkg::QMF_TX_CNT;
                end
            end
            qmf_pkg::QMF_TX_CNT: begin
                // Count bits 10-0 only; 15-11 are ignored
                st_nxt.tx_left = tx_mem[st_r.tx_rp[AW-1:0]][`QMF_LEN_HI:0];
                st_nxt.tx_rp   = st_r.tx_rp + 12'h001;
                st_nxt.tx_hi   = 1'b0;
                // Status now names the frame entering the MAC
                st_nxt.tx_stat = {10'h000, st_r.tx_ctrl[`QMF_TAG_HI:0]};
                st_nxt.tx_st   = qmf_pkg::QMF_TX_DATA;
            end
            qmf_pkg::QMF_TX_DATA: begin
                if (tx_out) begin
                    st_nxt.tx_left = st_r.tx_left - 11'h001;
                    st_nxt.tx_hi   = !st_r.tx_hi;
                    if (st_r.tx_hi || mac_tx_last) begin
                        st_nxt.tx_rp = st_r.tx_rp + 12'h001;
                    end
                    if (mac_tx_last) begin
                        st_nxt.tx_st = qmf_pkg::QMF_TX_DONE;
                    end
                end
            end
            qmf_pkg::QMF_TX_DONE: begin
                st_nxt.tx_stat[15] = 1'b1;
                st_nxt.tx_st       = qmf_pkg::QMF_TX_IDLE;
            end
            default: begin
                st_nxt.tx_st = qmf_pkg::QMF_TX_IDLE;
            end
        endcase
        // Frame count: host last word in, completed frame out
        st_nxt.tx_frames = st_r.tx_frames + {10'h000, tx_take && q.tx_wlast}
                           - {10'h000, st_r.tx_st == qmf_pkg::QMF_TX_DONE};
        // Receive store: bytes pair into words, earlier byte low
        if (rx_take) begin
            st_nxt.rx_len = rx_len_n;
            if (!st_r.rx_len[0]) begin
                st_nxt.rx_lo = mac_rx_data;
            end
            if (st_r.rx_len[0] || mac_rx_last) begin
                st_nxt.rx_wp = st_r.rx_wp + 12'h001;
            end
            if (mac_rx_last) begin
                st_nxt.rx_len = 11'h000;
                if (rx_drop) begin
                    // Rewind; nothing of the frame becomes visible
                    st_nxt.rx_wp = st_r.rx_base + `QMF_OFS_DATA;
                end else begin
                    // Next frame starts right after the kept data
                    st_nxt.rx_base = st_r.rx_base + `QMF_OFS_DATA + qmf_words(rx_eff);
                    st_nxt.rx_wp   = st_r.rx_base + `QMF_OFS_DATA + `QMF_OFS_DATA + qmf_words(rx_eff);
                end
            end
        end
        // Receive read-out toward the host
        if (rd_take) begin
            st_nxt.rx_rp = st_r.rx_rp + 12'h001;
            case (st_r.rd_st)
                qmf_pkg::QMF_RD_STAT: begin
                    st_nxt.rd_st = qmf_pkg::QMF_RD_CNT;
                end
                qmf_pkg::QMF_RD_CNT: begin
                    st_nxt.rd_left = 11'(qmf_words(rx_mem[st_r.rx_rp[AW-1:0]][`QMF_LEN_HI:0]));
                    st_nxt.rd_st   = qmf_pkg::QMF_RD_DATA;
                end
                qmf_pkg::QMF_RD_DATA: begin
                    st_nxt.rd_left = st_r.rd_left - 11'h001;
                    if (q.rx_rlast) begin
                        st_nxt.rd_st = qmf_pkg::QMF_RD_STAT;
                    end
                end
                default: begin
                    st_nxt.rd_st = qmf_pkg::QMF_RD_STAT;
                end
            endcase
        end
        st_nxt.rx_frames = st_r.rx_frames + {10'h000, rx_commit} - {10'h000, rd_take && q.rx_rlast};
        // Sticky events; a new event beats a clear in the same cycle
        st_nxt.irq = st_r.irq & ~q.irq_clr;
        if (st_r.tx_st == qmf_pkg::QMF_TX_DONE && st_r.tx_ctrl[`QMF_IRQ_ON_DONE]) begin
            st_nxt.irq[`QMF_EV_TX] = 1'b1;
        end
        if (rx_commit) begin
            st_nxt.irq[`QMF_EV_RX] = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_r         <= '0;
            st_r.tx_st   <= qmf_pkg::QMF_TX_IDLE;
            st_r.rd_st   <= qmf_pkg::QMF_RD_STAT;
            st_r.rx_wp   <= `QMF_OFS_DATA; // Header slots reserved ahead
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Memory writes
    always_ff @(posedge clk) begin
        // Host words stored verbatim: addresses, length/type untouched
        if (tx_take) begin
            tx_mem[st_r.tx_wp[AW-1:0]] <= q.tx_wdata;
        end
        if (rx_take && (st_r.rx_len[0] || mac_rx_last)) begin
            rx_mem[st_r.rx_wp[AW-1:0]] <= st_r.rx_len[0] ? {mac_rx_data, st_r.rx_lo}
                                                          : {8'h00, mac_rx_data};
        end
        // Header written with the last data word, so the valid bit never shows a partial frame
        if (rx_commit) begin
            rx_mem[st_r.rx_base[AW-1:0]] <= rx_status;
            rx_mem[st_r.rx_base[AW-1:0] + AW'(`QMF_OFS_COUNT)] <= {5'h00, rx_eff};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    always_comb begin
        mac_tx_valid   = st_r.tx_st == qmf_pkg::QMF_TX_DATA;
        mac_tx_data    = st_r.tx_hi ? tx_mem[st_r.tx_rp[AW-1:0]][15:8]
                                    : tx_mem[st_r.tx_rp[AW-1:0]][7:0];
        mac_tx_last    = st_r.tx_left == 11'h001;
        mac_tx_ports   = st_r.tx_ctrl[`QMF_PORT_HI:`QMF_PORT_LO];
        mac_tx_lookup  = st_r.tx_ctrl[`QMF_PORT_HI:`QMF_PORT_LO] == 2'b00;
        mac_tx_add_fcs = q.crc_gen_en;
    end

    assign q.rx_rvalid        = st_r.rx_frames != 11'h000;
    assign q.rx_rdata         = rx_mem[st_r.rx_rp[AW-1:0]];
    assign q.rx_rlast         = (st_r.rd_st == qmf_pkg::QMF_RD_DATA) && (st_r.rd_left == 11'h001);
    assign q.irq_flags        = st_r.irq;
    assign q.send_status_word = st_r.tx_stat;
endmodule
`default_nettype wire

// ===== hw/qmf_host.sv
// Host end: APB register slave that loads and drains the packet queues.
`timescale 1ns/1ns
`default_nettype none
`include "qmf_params.svh"
module qmf_host (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    qmf_if.host              q
);
    ////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        qmf_pkg::qmf_hs_e st;    // Frame loading state
        logic [31:0]      ctrl;  // Control word and checksum options
        logic [10:0]      len;   // Byte count of frame being loaded
        logic [10:0]      left;  // Data words still expected
    } qmf_host_s;

    qmf_host_s st_r;
    qmf_host_s st_nxt;

    // Plain address match; the access phase is not checked here
    function automatic logic qmf_hit(input logic [11:0] a, input logic [11:0] ofs);
        return a == ofs;
    endfunction

    logic access;   // APB access phase
    logic len_bad;  // Refused byte count
    logic data_ok;  // A data write may go out now

    always_comb begin
        access  = psel && penable;
        // Count must be nonzero and fit the data area
        len_bad = (pwdata[`QMF_LEN_HI:0] == 11'h000) || (pwdata[`QMF_LEN_HI:0] > `QMF_MAX_DATA)
                  || (st_r.st != qmf_pkg::QMF_HS_IDLE);
        data_ok = st_r.st == qmf_pkg::QMF_HS_DATA;
    end

    ////////////////////////////////////////////////////////////////////////
    // Link drive: header words first, then data words from writes
    always_comb begin
        q.tx_wvalid = 1'b0;
        q.tx_wdata  = 16'h0000;
        q.tx_wlast  = 1'b0;
        case (st_r.st)
            qmf_pkg::QMF_HS_CTRL: begin
                // Exactly one control word per frame, on a word slot
                q.tx_wvalid = 1'b1;
                q.tx_wdata  = st_r.ctrl[15:0];
            end
            qmf_pkg::QMF_HS_LEN: begin
                q.tx_wvalid = 1'b1;
                q.tx_wdata  = {5'h00, st_r.len};
            end
            qmf_pkg::QMF_HS_DATA: begin
                // Software supplies every byte, earlier byte low
                q.tx_wvalid = access && pwrite && qmf_hit(paddr, `QMF_REG_TXDATA);
                q.tx_wdata  = pwdata[15:0];
                q.tx_wlast  = st_r.left == 11'h001;
            end
            default: begin
                q.tx_wvalid = 1'b0;
            end
        endcase
    end

    assign q.crc_gen_en   = st_r.ctrl[`QMF_CTRL_GEN_FCS];
    assign q.crc_strip_en = st_r.ctrl[`QMF_CTRL_STRIP];
    assign q.rx_rready    = access && !pwrite && qmf_hit(paddr, `QMF_REG_RXDATA) && q.rx_rvalid;
    assign q.irq_clr      = (access && pwrite && qmf_hit(paddr, `QMF_REG_STATUS)) ? pwdata[1:0] : 2'b00;

    ////////////////////////////////////////////////////////////////////////
    // APB answer; only a data write can wait, on device room
    always_comb begin
        pready  = 1'b1;
        pslverr = 1'b0;
        prdata  = 32'h00000000;
        if (qmf_hit(paddr, `QMF_REG_CTRL)) begin
            prdata = st_r.ctrl;
        end else if (qmf_hit(paddr, `QMF_REG_LEN)) begin
            prdata  = {21'h000000, st_r.len};
            pslverr = pwrite && len_bad;
        end else if (qmf_hit(paddr, `QMF_REG_TXDATA)) begin
            pready  = !(pwrite && data_ok) || q.tx_wready;
            pslverr = !pwrite || !data_ok;
        end else if (qmf_hit(paddr, `QMF_REG_RXDATA)) begin
            // Empty queue reads as zero with the valid flag clear
            prdata = q.rx_rvalid ? {14'h0000, 1'b1, q.rx_rlast, q.rx_rdata} : 32'h00000000;
        end else if (qmf_hit(paddr, `QMF_REG_STATUS)) begin
            prdata = {q.send_status_word, 12'h000, !data_ok && st_r.st != qmf_pkg::QMF_HS_IDLE,
                      data_ok, q.irq_flags};
        end else begin
            // Unmapped address
            pslverr = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        st_nxt = st_r;
        if (access && pwrite && qmf_hit(paddr, `QMF_REG_CTRL)) begin
            st_nxt.ctrl = pwdata;
        end
        case (st_r.st)
            qmf_pkg::QMF_HS_IDLE: begin
                if (access && pwrite && qmf_hit(paddr, `QMF_REG_LEN) && !len_bad) begin
                    st_nxt.len = pwdata[`QMF_LEN_HI:0];
                    st_nxt.st  = qmf_pkg::QMF_HS_CTRL;
                end
            end
            qmf_pkg::QMF_HS_CTRL: begin
                if (q.tx_wready) begin
                    st_nxt.st = qmf_pkg::QMF_HS_LEN;
                end
            end
            qmf_pkg::QMF_HS_LEN: begin
                if (q.tx_wready) begin
                    st_nxt.left = st_r.len[10:1] + {10'h000, st_r.len[0]};
                    st_nxt.st   = qmf_pkg::QMF_HS_DATA;
                end
            end
            qmf_pkg::QMF_HS_DATA: begin
                if (q.tx_wvalid && q.tx_wready) begin
                    st_nxt.left = st_r.left - 11'h001;
                    if (q.tx_wlast) begin
                        st_nxt.st = qmf_pkg::QMF_HS_IDLE;
                    end
                end
            end
            default: begin
                st_nxt.st = qmf_pkg::QMF_HS_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_r      <= '0;
            st_r.st   <= qmf_pkg::QMF_HS_IDLE;
            st_r.ctrl <= `QMF_CTRL_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule
`default_nettype wire

// ===== hw/qmf_if.sv
// Queue word link between the host end and the device end.
`timescale 1ns/1ns
`default_nettype none
interface qmf_if;
    logic        tx_wvalid;        // Host offers a transmit queue word
    logic        tx_wready;        // Device has room for it
    logic [15:0] tx_wdata;         // Queue word, earlier byte in bits 7:0
    logic        tx_wlast;         // Last word of the frame
    logic        rx_rvalid;        // Device presents a receive queue word
    logic        rx_rready;        // Host takes it
    logic [15:0] rx_rdata;         // Receive queue word
    logic        rx_rlast;         // Last word of the frame
    logic        crc_gen_en;       // Hardware appends checksum on transmit
    logic        crc_strip_en;     // Hardware strips checksum on receive
    logic [1:0]  irq_flags;        // Sticky transmit/receive events
    logic [1:0]  irq_clr;          // One-cycle clear pulses
    logic [15:0] send_status_word; // Status of frame on the MAC side
    modport dev (input tx_wvalid, tx_wdata, tx_wlast, rx_rready, crc_gen_en, crc_strip_en, irq_clr,
                 output tx_wready, rx_rvalid, rx_rdata, rx_rlast, irq_flags, send_status_word);
    modport host (output tx_wvalid, tx_wdata, tx_wlast, rx_rready, crc_gen_en, crc_strip_en, irq_clr,
                  input tx_wready, rx_rvalid, rx_rdata, rx_rlast, irq_flags, send_status_word);
endinterface
`default_nettype wire

// ===== hw/qmf_params.svh
// Constants for the host packet queue framing block: layout, fields, offsets.
`ifndef QMF_PARAMS_SVH
`define QMF_PARAMS_SVH
// Packet memory: 4KB each, as 2048 words of 16 bits
`define QMF_ADDR_W        11
`define QMF_PTR_W         12
`define QMF_DEPTH         12'h800
`define QMF_MAX_DATA      11'h77C
`define QMF_FCS_BYTES     11'h004
// Word offsets of the header words inside a queued frame
`define QMF_OFS_CTRL      12'h000
`define QMF_OFS_COUNT     12'h001
`define QMF_OFS_DATA      12'h002
// Control word and byte count fields
`define QMF_IRQ_ON_DONE   15
`define QMF_PORT_HI       9
`define QMF_PORT_LO       8
`define QMF_TAG_HI        5
`define QMF_LEN_HI        10
// Receive status word fields
`define QMF_ARRIVED_VALID 15
// Sticky event flags
`define QMF_EV_TX         0
`define QMF_EV_RX         1
// Host register byte offsets
`define QMF_REG_CTRL      12'h000
`define QMF_REG_LEN       12'h004
`define QMF_REG_TXDATA    12'h008
`define QMF_REG_RXDATA    12'h00C
`define QMF_REG_STATUS    12'h010
// Host control register bits beyond the control word
`define QMF_CTRL_GEN_FCS  16
`define QMF_CTRL_STRIP    17
`define QMF_CTRL_RESET    32'h00000000
`endif

// ===== hw/qmf_pkg.sv
// Types shared by both ends of the host packet queue framing block.
package qmf_pkg;
    // Device transmit drain states
    typedef enum logic [3:0] {
        QMF_TX_IDLE = 4'h1,
        QMF_TX_CNT  = 4'h2,
        QMF_TX_DATA = 4'h4,
        QMF_TX_DONE = 4'h8
    } qmf_tx_e;
    // Device receive read-out states
    typedef enum logic [2:0] {
        QMF_RD_STAT = 3'h1,
        QMF_RD_CNT  = 3'h2,
        QMF_RD_DATA = 3'h4
    } qmf_rd_e;
    // Host frame loading states
    typedef enum logic [3:0] {
        QMF_HS_IDLE = 4'h1,
        QMF_HS_CTRL = 4'h2,
        QMF_HS_LEN  = 4'h4,
        QMF_HS_DATA = 4'h8
    } qmf_hs_e;
endpackage

// ===== tb/host_packet_queue_framing_tb_top.sv
// Self-checking bench for both ends of the packet queue framing block.
`timescale 1ns/1ns
`default_nettype none
module host_packet_queue_framing_tb_top;
    logic        clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata, rd;
    logic        pready, pslverr, mac_tx_valid, mac_tx_last, mac_tx_lookup, mac_tx_add_fcs, mac_rx_ready;
    logic        mac_tx_ready = 1'b0, mac_rx_valid = 1'b0, mac_rx_last = 1'b0;
    logic [7:0]  mac_tx_data, mac_rx_data = 8'h00;
    logic [1:0]  mac_tx_ports, mac_rx_port = 2'h2;
    logic [12:0] seen[$];      // Bytes sent with their sideband
    int          mismatches = 0, comparisons = 0;
    qmf_if q();
    qmf_host qmf_host_i (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .q(q));
    qmf_device qmf_device_i (.clk(clk), .rst_b(rst_b), .q(q), .mac_tx_valid(mac_tx_valid),
        .mac_tx_ready(mac_tx_ready), .mac_tx_data(mac_tx_data), .mac_tx_last(mac_tx_last),
        .mac_tx_ports(mac_tx_ports), .mac_tx_lookup(mac_tx_lookup), .mac_tx_add_fcs(mac_tx_add_fcs),
        .mac_rx_valid(mac_rx_valid), .mac_rx_ready(mac_rx_ready), .mac_rx_data(mac_rx_data),
        .mac_rx_last(mac_rx_last), .mac_rx_port(mac_rx_port));
    qmf_properties qmf_properties_i (.clk(clk), .rst_b(rst_b), .tx_wvalid(q.tx_wvalid), .tx_wready(q.tx_wready),
        .tx_wdata(q.tx_wdata), .rx_rvalid(q.rx_rvalid), .rx_rready(q.rx_rready), .rx_rdata(q.rx_rdata),
        .irq_flags(q.irq_flags), .irq_clr(q.irq_clr), .send_status_word(q.send_status_word));
    ////////////////////////////////////////
    initial begin
        forever #50 clk = ~clk;
    end
    // MAC side stalls every other cycle so the drain must wait
    always @(posedge clk) begin
        mac_tx_ready <= ~mac_tx_ready;
        if (mac_tx_valid && mac_tx_ready) seen.push_back({mac_tx_last, mac_tx_lookup, mac_tx_add_fcs, mac_tx_ports, mac_tx_data});
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            mismatches++;
            $display("unexpected %0t %h %h", $time, s, e);
        end
    endtask
    // One APB transfer; waits on pready, never on a fixed count
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        {rd, err} = {prdata, pslverr};
        {psel, penable} <= 2'h0;
    endtask
    task automatic refuse;
        apb(1'b1, 12'h004, 32'h00000000);
        chk(err, 1'b1);
        apb(1'b1, 12'h004, 32'h0000077D);
        chk(err, 1'b1);
        apb(1'b1, 12'h008, 32'h00000000);
        chk(err, 1'b1);
        apb(1'b0, 12'h020, 32'h00000000);
        chk(err, 1'b1);
    endtask
    // Odd 13-byte frame, port code p, tag follows p
    task automatic tx_frame(input logic [1:0] p);
        seen.delete();
        apb(1'b1, 12'h000, {14'h0000, 1'b1, p[0], 6'h20, p, 4'h0, p, 2'h1});
        apb(1'b1, 12'h004, 32'h0000000D);
        for (int k = 0; k < 7; k++) apb(1'b1, 12'h008, {16'h0000, 8'(8'h31 + 2 * k), 8'(8'h30 + 2 * k)});
        for (int i = 0; i < 300 && seen.size() < 13; i++) @(posedge clk);
        for (int i = 0; i < 13; i++) begin
            chk(seen[i], {i == 12, p == 2'h0, p[0], p, 8'(8'h30 + i)});
        end
        apb(1'b0, 12'h010, 32'h00000000);
        chk(rd & 32'h803F0001, {8'h80, 4'h0, p, 2'h1, 15'h0000, 1'b1});
        apb(1'b1, 12'h010, 32'h00000001);
        apb(1'b0, 12'h010, 32'h00000000);
        chk(rd[0], 1'b0);
    endtask
    // Ten bytes in from port 2, checksum stripped, then read back
    task automatic rx_frame;
        for (int i = 0; i < 10; i++) begin
            {mac_rx_valid, mac_rx_last, mac_rx_data} <= {1'b1, i == 9, 8'(8'h50 + i)};
            do @(posedge clk); while (mac_rx_ready !== 1'b1);
        end
        mac_rx_valid <= 1'b0;
        apb(1'b0, 12'h010, 32'h00000000);
        chk(rd[1], 1'b1);
        apb(1'b1, 12'h010, 32'h00000002);
        for (int k = 0; k < 6; k++) begin
            apb(1'b0, 12'h00C, 32'h00000000);
            chk(rd[17:0], k == 0 ? 18'h28200 : k == 1 ? 18'h20006 : k == 5 ? 18'h00000 :
                {1'b1, k == 4, 8'(8'h4D + 2 * k), 8'(8'h4C + 2 * k)});
        end
    endtask
    task automatic final_report;
        if (mismatches == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        #3000000;
        mismatches++;
        final_report();
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        refuse();
        for (int p = 0; p < 4; p++) tx_frame(2'(p));
        rx_frame();
        final_report();
    end
endmodule
`default_nettype wire

// ===== tb/qmf_properties.sv
// Checker for the queue word link between the host end and the device end.
`timescale 1ns/1ns
`default_nettype none
module qmf_properties (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        tx_wvalid,
    input wire logic        tx_wready,
    input wire logic [15:0] tx_wdata,
    input wire logic        rx_rvalid,
    input wire logic        rx_rready,
    input wire logic [15:0] rx_rdata,
    input wire logic [1:0]  irq_flags,
    input wire logic [1:0]  irq_clr,
    input wire logic [15:0] send_status_word
);
    // One clock domain, so clocking and reset are given once
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////
    reset_idle_a: assert property ($rose(rst_b) |-> irq_flags == 2'h0 && !rx_rvalid && tx_wready)
        else $error("link not idle after reset");
    tx_event_a: assert property (irq_flags[0] && !irq_clr[0] |=> irq_flags[0])
        else $error("transmit event lost");
    rx_clear_a: assert property ($fell(irq_flags[1]) |-> $past(irq_clr[1]))
        else $error("receive event dropped without clear");
    rx_event_a: assert property ($rose(rx_rvalid) |-> ##[0:1] irq_flags[1])
        else $error("receive frame without event");
    tx_done_a: assert property ($rose(irq_flags[0]) |-> send_status_word[15])
        else $error("transmit event before frame done");
    rx_status_a: assert property ($rose(rx_rvalid) |-> rx_rdata[15:8] inside {8'h81, 8'h82})
        else $error("bad receive status word");
    rx_hold_a: assert property (rx_rvalid && !rx_rready |=> rx_rvalid && $stable(rx_rdata))
        else $error("receive word changed while waiting");
    tx_hold_a: assert property (tx_wvalid && !tx_wready |=> tx_wvalid && $stable(tx_wdata))
        else $error("transmit word changed while waiting");
endmodule
`default_nettype wire
